// File: verilog/cce_exec.sv
// Purpose: Executes carry toggle, zeroing, invert, compare and compare-step-branch
// Assumes: Decode holds START one cycle with REQ valid; register file applies REG/PTR writes
// Notes: Owns the status flag register; other instructions load it through FLG_LD
//
// Functional notes
// - Carry toggle inverts carry only, 4 cycles
// - Carry lives in flag register at D5
// - Zeroing writes 00h, no flags, 4 cycles
// - Pointer zeroing clears pointed register, pointer kept
// - Invert complements destination, both forms 4 cycles
// - Invert sets Z, S; clears V
// - Compare updates flags only, writes no operand
// - Compare carry on borrow, Z, S, V
// - Equal step-branch jumps when difference zero
// - Unequal step-branch jumps when difference nonzero
// - Step-branch always increments source pointer
// - Step-branch takes 18 taken, 16 not
// - Branch offset is signed, -128 to +127
`timescale 1ns/1ps
module cce_exec
  import cce_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Request from decode
  input wire logic START,
  input wire cce_req_s REQ,
  // Flag load by other instructions
  input wire logic FLG_LD,
  input wire logic [7:0] FLG_DIN,
  // Register file write
  output logic REG_WE,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  // Source pointer write
  output logic PTR_WE,
  output logic [7:0] PTR_ADDR,
  output logic [7:0] PTR_WDATA,
  // Program counter
  output logic PC_WE,
  output logic [15:0] PC_NEXT,
  // Status
  output logic [7:0] FLAGS,
  output logic BUSY,
  output logic DONE
);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  cce_state_e state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  cce_res_s hold_ff, nxt_hold;
  logic [7:0] ptr_addr_ff, nxt_ptr_addr;
  logic [7:0] ptr_val_ff, nxt_ptr_val;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] flags_ff, nxt_flags;
  logic reg_we_ff, nxt_reg_we;
  logic [7:0] reg_addr_ff, nxt_reg_addr;
  logic [7:0] reg_wdata_ff, nxt_reg_wdata;
  logic ptr_we_ff, nxt_ptr_we;
  logic [7:0] ptr_wdata_ff, nxt_ptr_wdata;
  logic pc_we_ff, nxt_pc_we;
  logic [15:0] pc_next_ff, nxt_pc_next;
  logic done_ff, nxt_done;
  logic busy_ff, nxt_busy;
  cce_res_s alu_res;
  logic accept;
  logic finish;

  // Reset is released through two stages so its removal is clean
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  cce_alu u_alu (
    .req(REQ),
    .flags_in(flags_ff),
    .res(alu_res)
  );

  // Unknown opcodes are not accepted, so decode sees no BUSY for them
  assign accept = (state_ff == CCE_IDLE) && START && alu_res.legal;
  assign finish = (state_ff == CCE_RUN) && (cnt_ff == CYC_ONE);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_hold = hold_ff;
    nxt_ptr_addr = ptr_addr_ff;
    nxt_ptr_val = ptr_val_ff;
    nxt_pc = pc_ff;
    nxt_busy = busy_ff;
    case (state_ff)
      CCE_IDLE:
      begin
        if (accept)
        begin
          nxt_state = CCE_RUN;
          nxt_cnt = alu_res.cycles - CYC_ONE;
          nxt_hold = alu_res;
          nxt_ptr_addr = REQ.ptr_addr;
          nxt_ptr_val = REQ.ptr_val;
          nxt_pc = REQ.pc;
          nxt_busy = 1'b1;
        end
      end
      CCE_RUN:
      begin
        nxt_cnt = cnt_ff - CYC_ONE;
        if (finish)
        begin
          nxt_state = CCE_IDLE;
          nxt_busy = 1'b0;
        end
      end
      default:
      begin
        nxt_state = CCE_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  // All writes land together in the instruction's last cycle
  always_comb
  begin
    nxt_done = finish;
    nxt_reg_we = finish && hold_ff.wr_en;
    nxt_reg_addr = hold_ff.wr_addr;
    nxt_reg_wdata = hold_ff.result;
    nxt_ptr_we = finish && hold_ff.ptr_we;
    nxt_ptr_wdata = ptr_val_ff + PTR_STEP;
    nxt_pc_we = finish && hold_ff.take;
    nxt_pc_next = hold_ff.target;
    nxt_flags = flags_ff;
    // Own update wins over an outside load in the same cycle
    if (finish)
    begin
      nxt_flags = hold_ff.flags;
      if (hold_ff.wr_en && (hold_ff.wr_addr == FLAGS_ADDR))
      begin
        nxt_flags = hold_ff.result;
      end
    end
    else if (FLG_LD)
    begin
      nxt_flags = FLG_DIN;
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= CCE_IDLE;
      cnt_ff <= 5'h00;
      hold_ff <= '0;
      ptr_addr_ff <= 8'h00;
      ptr_val_ff <= 8'h00;
      pc_ff <= 16'h0000;
      busy_ff <= 1'b0;
      flags_ff <= FLAGS_RST;
      reg_we_ff <= 1'b0;
      reg_addr_ff <= 8'h00;
      reg_wdata_ff <= 8'h00;
      ptr_we_ff <= 1'b0;
      ptr_wdata_ff <= 8'h00;
      pc_we_ff <= 1'b0;
      pc_next_ff <= 16'h0000;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      hold_ff <= nxt_hold;
      ptr_addr_ff <= nxt_ptr_addr;
      ptr_val_ff <= nxt_ptr_val;
      pc_ff <= nxt_pc;
      busy_ff <= nxt_busy;
      flags_ff <= nxt_flags;
      reg_we_ff <= nxt_reg_we;
      reg_addr_ff <= nxt_reg_addr;
      reg_wdata_ff <= nxt_reg_wdata;
      ptr_we_ff <= nxt_ptr_we;
      ptr_wdata_ff <= nxt_ptr_wdata;
      pc_we_ff <= nxt_pc_we;
      pc_next_ff <= nxt_pc_next;
      done_ff <= nxt_done;
    end
  end

  assign REG_WE = reg_we_ff;
  assign REG_ADDR = reg_addr_ff;
  assign REG_WDATA = reg_wdata_ff;
  assign PTR_WE = ptr_we_ff;
  assign PTR_ADDR = ptr_addr_ff;
  assign PTR_WDATA = ptr_wdata_ff;
  assign PC_WE = pc_we_ff;
  assign PC_NEXT = pc_next_ff;
  assign FLAGS = flags_ff;
  assign BUSY = busy_ff;
  assign DONE = done_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  logic [15:0] exp_target;
  logic [15:0] pc_delta;
  assign exp_target = cce_rel_target(REQ.pc, REQ.rel_offset);
  assign pc_delta = PC_NEXT - pc_ff;

  sequence s_ends_short;
    ##3 !DONE ##1 DONE;
  endsequence

  carry_toggle_a: assert property ((accept && REQ.opcode == OP_CARRY_TOGGLE) |->
    s_ends_short ##0 (FLAGS == ($past(flags_ff, 4) ^ 8'h80)))
    else $error("carry toggle wrong");
  flags_addr_a: assert property ((accept && REQ.opcode == OP_ZERO_R
    && REQ.dst_addr == FLAGS_ADDR) |-> ##4 (FLAGS == 8'h00))
    else $error("flag register not cleared");
  zero_write_a: assert property ((accept && REQ.opcode == OP_ZERO_R) |->
    s_ends_short ##0 (REG_WE && REG_WDATA == 8'h00 && REG_ADDR == $past(REQ.dst_addr, 4)))
    else $error("zeroing write wrong");
  zero_pointer_a: assert property ((accept && REQ.opcode == OP_ZERO_PTR) |->
    ##4 (REG_WE && !PTR_WE && REG_ADDR == $past(REQ.ptr_val, 4)))
    else $error("pointer zeroing address wrong");
  invert_data_a: assert property ((accept && (REQ.opcode == OP_INV_R
    || REQ.opcode == OP_INV_PTR)) |-> s_ends_short ##0 (REG_WDATA == ~$past(REQ.dst_val, 4)))
    else $error("invert result wrong");
  invert_flags_a: assert property ((accept && REQ.opcode == OP_INV_R
    && REQ.dst_addr != FLAGS_ADDR) |-> ##4 (!FLAGS[FLG_V]
    && FLAGS[FLG_Z] == (REG_WDATA == 8'h00) && FLAGS[FLG_S] == REG_WDATA[7]
    && FLAGS[7] == $past(flags_ff[7], 4)))
    else $error("invert flags wrong");
  test_nowrite_a: assert property ((accept && cce_is_test(REQ.opcode)) |->
    (!REG_WE && !PTR_WE && !PC_WE) [*7])
    else $error("compare wrote an operand");
  test_carry_a: assert property ((accept && REQ.opcode == OP_TEST_WW) |->
    ##4 (FLAGS[FLG_C] == ($past(REQ.src_val, 4) > $past(REQ.dst_val, 4))))
    else $error("compare carry wrong");
  test_overflow_a: assert property ((accept && REQ.opcode == OP_TEST_WW) |->
    ##4 (FLAGS[FLG_V] == (($past(REQ.dst_val[7], 4) != $past(REQ.src_val[7], 4))
    && ($past(REQ.dst_val[7], 4) != FLAGS[FLG_S]))))
    else $error("compare overflow wrong");
  branch_equal_a: assert property ((accept && REQ.opcode == OP_TSB_EQ
    && REQ.dst_val == REQ.src_val) |-> ##18 (PC_WE && PC_NEXT == $past(exp_target, 18)))
    else $error("equal branch not taken");
  branch_unequal_a: assert property ((accept && REQ.opcode == OP_TSB_NE
    && REQ.dst_val == REQ.src_val) |-> ##16 (DONE && !PC_WE))
    else $error("unequal branch taken on equal");
  pointer_step_a: assert property ((accept && cce_is_branch(REQ.opcode)
    && REQ.dst_val == REQ.src_val) |-> ##[16:18] (PTR_WE
    && PTR_WDATA == ptr_val_ff + 8'h01 && PTR_ADDR == ptr_addr_ff))
    else $error("pointer not stepped");
  branch_time_a: assert property ((accept && REQ.opcode == OP_TSB_NE
    && REQ.dst_val != REQ.src_val) |-> ##17 (BUSY && !DONE) ##1 DONE)
    else $error("taken branch time wrong");
  branch_range_a: assert property (PC_WE |->
    (pc_delta <= 16'h007f || pc_delta >= 16'hff80))
    else $error("branch offset out of range");

endmodule

// File: verilog/cce_pkg.sv
// Purpose: Shared constants and types for the compare/complement/clear execution block
// Assumes: Core fetch/decode supplies operand values already read from the register file
// Notes: Flag bit positions follow the core's status register layout
package cce_pkg;

  // Opcodes handled by this block
  localparam logic [7:0] OP_CARRY_TOGGLE = 8'hef;
  localparam logic [7:0] OP_ZERO_R = 8'hb0;
  localparam logic [7:0] OP_ZERO_PTR = 8'hb1;
  localparam logic [7:0] OP_INV_R = 8'h60;
  localparam logic [7:0] OP_INV_PTR = 8'h61;
  localparam logic [7:0] OP_TEST_WW = 8'ha2;
  localparam logic [7:0] OP_TEST_WI = 8'ha3;
  localparam logic [7:0] OP_TEST_RR = 8'ha4;
  localparam logic [7:0] OP_TEST_RI = 8'ha5;
  localparam logic [7:0] OP_TEST_LIT = 8'ha6;
  localparam logic [7:0] OP_TSB_EQ = 8'hc2;
  localparam logic [7:0] OP_TSB_NE = 8'hd2;

  // Status flag register address and bit positions
  localparam logic [7:0] FLAGS_ADDR = 8'hd5;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;

  // Execution times in core clock cycles
  localparam logic [4:0] CYC_SHORT = 5'h04;
  localparam logic [4:0] CYC_TEST_LONG = 5'h06;
  localparam logic [4:0] CYC_BR_TAKEN = 5'h12;
  localparam logic [4:0] CYC_BR_NOT = 5'h10;
  localparam logic [4:0] CYC_ONE = 5'h01;

  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic {CCE_IDLE, CCE_RUN} cce_state_e;

  // Operands presented by decode with the start strobe
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst_addr;
    logic [7:0] dst_val;
    logic [7:0] src_val;
    logic [7:0] ptr_addr;
    logic [7:0] ptr_val;
    logic [7:0] rel_offset;
    logic [15:0] pc;
  } cce_req_s;

  // Outcome of one instruction
  typedef struct packed {
    logic legal;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] result;
    logic [7:0] flags;
    logic ptr_we;
    logic take;
    logic [15:0] target;
    logic [4:0] cycles;
  } cce_res_s;

  function automatic logic cce_is_branch(input logic [7:0] op);
    return (op == OP_TSB_EQ) || (op == OP_TSB_NE);
  endfunction

  function automatic logic cce_is_test(input logic [7:0] op);
    return (op == OP_TEST_WW) || (op == OP_TEST_WI) || (op == OP_TEST_RR)
      || (op == OP_TEST_RI) || (op == OP_TEST_LIT);
  endfunction

  function automatic logic [15:0] cce_rel_target(input logic [15:0] pc, input logic [7:0] rel);
    return pc + {{8{rel[7]}}, rel};
  endfunction

endpackage

// File: verilog/cce_alu.sv
// Purpose: Combinational result, flag and branch computation for one instruction
// Assumes: Operands are stable while the start strobe is sampled
// Notes: Unknown opcodes come back with legal low and change nothing
`timescale 1ns/1ps
module cce_alu
  import cce_pkg::*;
(
  // Request and current status
  input wire cce_req_s req,
  input wire logic [7:0] flags_in,
  // Outcome
  output cce_res_s res
);

  logic [8:0] diff;
  logic [7:0] d8;
  logic [7:0] inv;

  assign diff = {1'b0, req.dst_val} - {1'b0, req.src_val};
  assign d8 = diff[7:0];
  assign inv = ~req.dst_val;

  always_comb
  begin
    res = '0;
    res.legal = 1'b1;
    res.flags = flags_in;
    res.wr_addr = req.dst_addr;
    res.cycles = CYC_SHORT;
    res.target = cce_rel_target(req.pc, req.rel_offset);
    case (req.opcode)
      OP_CARRY_TOGGLE:
      begin
        res.flags[FLG_C] = ~flags_in[FLG_C];
      end
      OP_ZERO_R, OP_ZERO_PTR:
      begin
        res.wr_en = 1'b1;
        res.result = ZERO_BYTE;
        // Pointer form writes where the pointer points, pointer untouched
        if (req.opcode == OP_ZERO_PTR)
        begin
          res.wr_addr = req.ptr_val;
        end
      end
      OP_INV_R, OP_INV_PTR:
      begin
        res.wr_en = 1'b1;
        res.result = inv;
        if (req.opcode == OP_INV_PTR)
        begin
          res.wr_addr = req.ptr_val;
        end
        res.flags[FLG_Z] = (inv == ZERO_BYTE);
        res.flags[FLG_S] = inv[7];
        res.flags[FLG_V] = 1'b0;
      end
      OP_TEST_WW, OP_TEST_WI, OP_TEST_RR, OP_TEST_RI, OP_TEST_LIT:
      begin
        if (req.opcode != OP_TEST_WW)
        begin
          res.cycles = CYC_TEST_LONG;
        end
        res.flags[FLG_C] = diff[8];
        res.flags[FLG_Z] = (d8 == ZERO_BYTE);
        res.flags[FLG_S] = d8[7];
        res.flags[FLG_V] = (req.dst_val[7] != req.src_val[7])
          && (d8[7] != req.dst_val[7]);
      end
      OP_TSB_EQ, OP_TSB_NE:
      begin
        res.ptr_we = 1'b1;
        res.take = (req.opcode == OP_TSB_EQ) ? (d8 == ZERO_BYTE)
          : (d8 != ZERO_BYTE);
        res.cycles = res.take ? CYC_BR_TAKEN : CYC_BR_NOT;
      end
      default:
      begin
        res.legal = 1'b0;
      end
    endcase
  end

endmodule

// File: testbench/tb.sv
// Purpose: Self-checking bench for the compare/complement/clear execution block
// Assumes: Decode-style stimulus at the falling edge, one instruction at a time
// Notes: Expected values are worked out here by hand, never read back from the block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb
  import cce_pkg::*;
();
  logic clk;
  logic rst_n;
  logic start;
  cce_req_s req;
  logic flg_ld;
  logic [7:0] flg_din;
  logic reg_we, ptr_we, pc_we, busy, done;
  logic [7:0] reg_addr, reg_wdata, ptr_addr, ptr_wdata, flags;
  logic [15:0] pc_next;
  int fails;
  int total_checks;
  logic [5:0] ncyc, reg_hits, ptr_hits, pc_hits;

  cce_exec uut (.CLK(clk), .RST_N(rst_n), .START(start), .REQ(req), .FLG_LD(flg_ld),
    .FLG_DIN(flg_din), .REG_WE(reg_we), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .PTR_WE(ptr_we), .PTR_ADDR(ptr_addr), .PTR_WDATA(ptr_wdata), .PC_WE(pc_we),
    .PC_NEXT(pc_next), .FLAGS(flags), .BUSY(busy), .DONE(done));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Issues one instruction and returns at the falling edge of its finishing cycle
  task automatic run(input logic [7:0] op, da, dv, sv, pa, pv, rel, input logic [15:0] pc);
    req = '{op, da, dv, sv, pa, pv, rel, pc};
    start = 1'b1;
    ncyc = 6'h00;
    reg_hits = 6'h00;
    ptr_hits = 6'h00;
    pc_hits = 6'h00;
    do
    begin
      @(negedge clk);
      start = 1'b0;
      ncyc++;
      reg_hits += reg_we;
      ptr_hits += ptr_we;
      pc_hits += pc_we;
    end while (done !== 1'b1 && ncyc < 6'h28);
    if (done !== 1'b1)
    begin
      fails++;
      $display("BAD done expected 1 seen %b", done);
    end
  endtask

  task automatic load_flags(input logic [7:0] v);
    flg_ld = 1'b1;
    flg_din = v;
    @(negedge clk);
    flg_ld = 1'b0;
  endtask

  task automatic t_toggle();
    load_flags(8'h5a);
    `CHK("flags load", 8'h5a, flags);
    run(OP_CARRY_TOGGLE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("toggle cycles", 6'h04, ncyc);
    `CHK("toggle set", 8'hda, flags);
    `CHK("toggle no write", 6'h00, reg_hits);
    run(OP_CARRY_TOGGLE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("toggle clear", 8'h5a, flags);
    $display("test toggle done");
  endtask

  task automatic t_zero();
    load_flags(8'hf0);
    run(OP_ZERO_R, 8'h21, 8'h4f, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("zero cycles", 6'h04, ncyc);
    `CHK("zero we", 6'h01, reg_hits);
    `CHK("zero addr", 8'h21, reg_addr);
    `CHK("zero data", 8'h00, reg_wdata);
    `CHK("zero flags", 8'hf0, flags);
    run(OP_ZERO_PTR, 8'h02, 8'h5e, 8'h00, 8'h01, 8'h02, 8'h00, 16'h0000);
    `CHK("zero ptr cycles", 6'h04, ncyc);
    `CHK("zero ptr addr", 8'h02, reg_addr);
    `CHK("zero ptr data", 8'h00, reg_wdata);
    `CHK("zero ptr kept", 6'h00, ptr_hits);
    // Clearing the status register itself must show through the flag output
    run(OP_ZERO_R, FLAGS_ADDR, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("flag reg cleared", 8'h00, flags);
    $display("test zero done");
  endtask

  task automatic t_invert();
    load_flags(8'h90);
    run(OP_INV_R, 8'h31, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("inv cycles", 6'h04, ncyc);
    `CHK("inv data", 8'h00, reg_wdata);
    `CHK("inv addr", 8'h31, reg_addr);
    `CHK("inv zero flags", 8'hc0, flags);
    run(OP_INV_PTR, 8'h07, 8'hf1, 8'h00, 8'h01, 8'h07, 8'h00, 16'h0000);
    `CHK("inv ptr cycles", 6'h04, ncyc);
    `CHK("inv ptr data", 8'h0e, reg_wdata);
    `CHK("inv ptr flags", 8'h80, flags);
    load_flags(8'h00);
    run(OP_INV_R, 8'h31, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("inv neg data", 8'hf8, reg_wdata);
    `CHK("inv neg flags", 8'h20, flags);
    $display("test invert done");
  endtask

  task automatic cmp(input logic [7:0] op, d, s, fx, input logic [5:0] cyc);
    run(op, 8'h12, d, s, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("cmp cycles", cyc, ncyc);
    `CHK("cmp no write", 6'h00, reg_hits);
    `CHK("cmp flags", fx, flags);
  endtask

  task automatic t_compare();
    load_flags(8'h0f);
    cmp(OP_TEST_WW, 8'h02, 8'h03, 8'haf, 6'h04);
    cmp(OP_TEST_WI, 8'h80, 8'h01, 8'h1f, 6'h06);
    cmp(OP_TEST_RR, 8'h44, 8'h44, 8'h4f, 6'h06);
    cmp(OP_TEST_RI, 8'h7f, 8'hff, 8'hbf, 6'h06);
    cmp(OP_TEST_LIT, 8'h10, 8'h01, 8'h0f, 6'h06);
    $display("test compare done");
  endtask

  task automatic br(input logic [7:0] op, d, s, pv, rel, input logic [15:0] pc, tgt,
                    input logic tk);
    run(op, 8'h01, d, s, 8'h02, pv, rel, pc);
    `CHK("br cycles", tk ? 6'h12 : 6'h10, ncyc);
    `CHK("br pc we", {5'h00, tk}, pc_hits);
    if (tk)
      `CHK("br target", tgt, pc_next);
    `CHK("br ptr we", 6'h01, ptr_hits);
    `CHK("br ptr addr", 8'h02, ptr_addr);
    `CHK("br ptr data", pv + 8'h01, ptr_wdata);
    `CHK("br flags", 8'h5a, flags);
    `CHK("br no write", 6'h00, reg_hits);
  endtask

  task automatic t_branch();
    load_flags(8'h5a);
    br(OP_TSB_EQ, 8'h02, 8'h02, 8'h03, 8'h80, 16'h1000, 16'h0f80, 1'b1);
    br(OP_TSB_EQ, 8'h02, 8'h04, 8'hff, 8'h10, 16'h1000, 16'h0000, 1'b0);
    br(OP_TSB_NE, 8'h02, 8'h04, 8'h03, 8'h7f, 16'h1000, 16'h107f, 1'b1);
    br(OP_TSB_NE, 8'h09, 8'h09, 8'h40, 8'h7f, 16'h1000, 16'h0000, 1'b0);
    $display("test branch done");
  endtask

  // A start while busy and an unknown opcode must both be ignored
  task automatic t_refused();
    logic [3:0] hits;
    req = '{OP_ZERO_R, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    req.dst_addr = 8'h44;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    hits = 4'h0;
    repeat (10)
    begin
      @(negedge clk);
      hits += done;
      if (done === 1'b1)
        `CHK("busy start addr", 8'h33, reg_addr);
    end
    `CHK("busy start dones", 4'h1, hits);
    req.opcode = 8'h00;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    hits = 4'h0;
    repeat (6)
    begin
      hits += busy;
      hits += done;
      @(negedge clk);
    end
    `CHK("illegal ignored", 4'h0, hits);
    $display("test refused done");
  endtask

  // Reset in mid-branch must drop busy, done, pointer and PC write strobes and flags, then the next instruction runs cleanly
  task automatic t_reset();
    load_flags(8'h5a);
    req = '{OP_TSB_EQ, 8'h01, 8'h02, 8'h02, 8'h02, 8'h03, 8'h10, 16'h1000};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("reset mid busy", 1'b0, busy);
    `CHK("reset mid done", 1'b0, done);
    `CHK("reset mid ptr we", 1'b0, ptr_we);
    `CHK("reset mid pc we", 1'b0, pc_we);
    `CHK("reset mid flags", FLAGS_RST, flags);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("reset after busy", 1'b0, busy);
    run(OP_CARRY_TOGGLE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
    `CHK("reset then cycles", 6'h04, ncyc);
    `CHK("reset then toggle", 8'h80, flags);
    `CHK("reset then no pc", 6'h00, pc_hits);
    $display("test reset done");
  endtask

  initial
  begin
    #(4000 * 40);
    fails++;
    $display("BAD watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial
  begin
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    start = 1'b0;
    req = '0;
    flg_ld = 1'b0;
    flg_din = 8'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("reset flags", FLAGS_RST, flags);
    `CHK("reset busy", 1'b0, busy);
    t_toggle();
    t_zero();
    t_invert();
    t_compare();
    t_branch();
    t_refused();
    t_reset();
    tally_and_finish();
  end
endmodule
